// ==== logic/pss_regs.svh ====
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
// register byte addresses
`define PSS_A_CTRL 8'h00
`define PSS_A_FLAGS 8'h04
`define PSS_A_MASK 8'h08
`define PSS_A_STATE 8'h0c
`define PSS_A_OUTEN 8'h10
`define PSS_A_KEEP 8'h14
`define PSS_A_SLOT0 8'h20
// control fields
`define PSS_CTRL_TB_LO 0
`define PSS_CTRL_GRP 2
`define PSS_CTRL_SDREQ 3
`define PSS_CTRL_EDGE 4
// flag fields
`define PSS_F_UP 0
`define PSS_F_DN 1
`define PSS_F_SD 2
// reset values
`define PSS_TB_RST 2'h0
`define PSS_MASK_RST 3'h0
`define PSS_KEEP_RST 8'h00
`define PSS_SLOT_RST 8'h00
// timing
`define PSS_CLK_MHZ 250
`define PSS_TB0_US 30
`define PSS_TB1_US 120
`define PSS_TB2_US 250
`define PSS_TB3_US 500
`define PSS_SDWN_US 500
`define PSS_HOLD_CYC 1000
`define PSS_DBNC_CYC 1000
`endif

// ==== logic/pss_pkg.sv ====
package pss_pkg;
  typedef enum logic [2:0] {
    ST_OFF, ST_UP, ST_RUN, ST_SBDN, ST_STBY, ST_SBUP, ST_DN, ST_FS
  } pss_state_t;
endpackage

// ==== logic/pss_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"

// Function
// R1 - two-bit time base select: 30, 120, 250 or 500 us, default from nonvolatile.
// R2 - live time base may be rewritten while on and governs later timing.
// R3 - each output has an 8-bit slot field; zero keeps it off, except the unslotted host reset (R6).
// R4 - nonzero field n selects slot n minus one, slots 0 to 254.
// R5 - slot 0 enables at once, slot k after k time-base periods.
// R6 - unslotted host reset releases in the same cycle as the last programmed output enables.
// R7 - all fields zero: run with nothing enabled, unslotted host reset released.
// R8 - standby to run sequences only if some regulator turns on.
// R9 - power-up flag set on every standby to run transition.
// R10 - level mode: power-on pin low starts power down.
// R11 - edge mode: falling edge held low past reset hold time starts power down.
// R12 - shutdown request starts 500 us timer, sets flag, drives interrupt unless masked.
// R13 - clearing flag cancels and resets timer, request self-clears; expiry powers down.
// R14 - fault timer, fault count, watchdog count or thermal start hard power down.
// R15 - after hard fault power down the device passes through fail-safe.
// R16 - power-down mode bit: 0 sequential, 1 grouped.
// R17 - run to standby sequences only if some regulator turns off.
// R18 - power-down flag set at end of every run to standby transition.
// R19 - sequential down: zero fields off at once, rest reverse order one period later.
// R20 - power-good output turns off at its own slot during power down.
// R21 - each off pass reloads time base and slot fields from nonvolatile values.
// R22 - power up accepted only with no trim, config, self-test error or overheat.
// R23 - off: level mode pin high, edge mode debounced fall, is power-up event.
// R24 - tick counter on the clock, slot counter compared with each field.
module pss_top import pss_pkg::*; #(
  parameter int NREG = 4,
  parameter int TB0_CYC = `PSS_TB0_US * `PSS_CLK_MHZ,
  parameter int TB1_CYC = `PSS_TB1_US * `PSS_CLK_MHZ,
  parameter int TB2_CYC = `PSS_TB2_US * `PSS_CLK_MHZ,
  parameter int TB3_CYC = `PSS_TB3_US * `PSS_CLK_MHZ,
  parameter int SDWN_CYC = `PSS_SDWN_US * `PSS_CLK_MHZ,
  parameter int HOLD_CYC = `PSS_HOLD_CYC,
  parameter int DBNC_CYC = `PSS_DBNC_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // nonvolatile defaults
  input wire logic [1:0] DEF_TIME_BASE_SEL,
  input wire logic [8*(NREG+2)-1:0] DEF_SLOT_FIELD,
  input wire logic DEF_EDGE_MODE,
  // host pin and system state
  input wire logic POWER_ON_PIN,
  input wire logic STANDBY_REQ,
  input wire logic FAULT_TIMER_EXP,
  input wire logic [3:0] FAULT_REPEAT_COUNT,
  input wire logic [3:0] FAULT_REPEAT_LIMIT,
  input wire logic [3:0] WATCHDOG_FAIL_COUNT,
  input wire logic [3:0] WATCHDOG_FAIL_LIMIT,
  input wire logic THERMAL_SHUTDOWN,
  input wire logic TRIM_ERROR_FLAG,
  input wire logic CONFIG_LOAD_ERROR_FLAG,
  input wire logic SELF_TEST_ERROR_FLAG,
  // sequenced outputs, interrupt and fail-safe
  output logic [NREG-1:0] REG_ENABLE,
  output logic POWER_GOOD_PIN,
  output logic HOST_RESET_N,
  output logic INTERRUPT_OUT_N,
  output logic FAIL_SAFE
);
  localparam int N = NREG + 2;
  localparam int HR = NREG + 1;

  pss_state_t state, next_state;
  logic [1:0] live_tb;
  logic grouped, edge_mode, hard;
  logic [N-1:0][7:0] slot;
  logic [NREG-1:0] stby_keep;
  logic [N-1:0] out_en, scope, next_scope;
  logic [2:0] irq_mask, flags;
  logic sd_req, sd_set, sd_clr, sd_exp;
  logic [31:0] tb_cnt, tb_period, sd_cnt, low_cnt;
  logic [8:0] cnt, maxp1;
  logic tick, seq_done, is_up, is_dn;
  logic pon_m, pon_s, pon_d, armed;
  logic pwr_ok, up_ev, pin_dn, fault_ev, stop_ev, on_st;

  ////////////////////////////////////////////////////////////////
  function automatic logic [N-1:0] scope_of(pss_state_t s, logic [NREG-1:0] k);
    // standby moves touch only regulators not kept alive
    if (s == ST_SBDN || s == ST_SBUP)
      return {2'b00, ~k};
    return {N{1'b1}};
  endfunction

  function automatic logic [8:0] top_field(logic [N-1:0] sc, logic [N-1:0][7:0] f);
    logic [8:0] m;
    m = 9'h000;
    for (int i = 0; i < N; i++) begin
      if (sc[i] && 9'(f[i]) > m)
        m = 9'(f[i]);
    end
    return m;
  endfunction

  assign scope = scope_of(state, stby_keep);
  assign next_scope = scope_of(next_state, stby_keep);
  assign maxp1 = top_field(scope, slot);
  assign is_up = (state == ST_UP) || (state == ST_SBUP);
  assign is_dn = (state == ST_DN) || (state == ST_SBDN);
  // R8 empty standby scope skips the sequencer
  // R17 empty scope gives zero top field, so the move ends at once
  assign seq_done = is_up ? (cnt >= maxp1) : (cnt == 9'h000);
  assign on_st = is_up || state == ST_RUN || state == ST_STBY || state == ST_SBDN;

  ////////////////////////////////////////////////////////////////
  // power-on pin, two flops before use
  always_ff @(posedge CLK) begin
    if (RST) begin
      pon_m <= 1'b0;
      pon_s <= 1'b0;
      pon_d <= 1'b0;
    end else begin
      pon_m <= POWER_ON_PIN;
      pon_s <= pon_m;
      pon_d <= pon_s;
    end
  end

  // R11 low time after a falling edge
  always_ff @(posedge CLK) begin
    if (RST) begin
      armed <= 1'b0;
      low_cnt <= 32'h0;
    end else if (pon_s || (edge_mode && (up_ev || (pin_dn && on_st)))) begin
      armed <= 1'b0;
      low_cnt <= 32'h0;
    end else if (pon_d) begin
      armed <= 1'b1;
      low_cnt <= 32'h0;
    end else if (armed && low_cnt != 32'hffff_ffff) begin
      low_cnt <= low_cnt + 32'h1;
    end
  end

  // R22 power-up gate
  assign pwr_ok = !(TRIM_ERROR_FLAG || CONFIG_LOAD_ERROR_FLAG || SELF_TEST_ERROR_FLAG ||
                    THERMAL_SHUTDOWN);
  // R23 power-up event
  assign up_ev = pwr_ok && (edge_mode ? (armed && low_cnt == 32'(DBNC_CYC)) : pon_s);
  // R10 level mode and R11 edge mode turn-off
  assign pin_dn = edge_mode ? (armed && low_cnt == 32'(HOLD_CYC)) : !pon_s;
  // R14 hard fault sources
  assign fault_ev = FAULT_TIMER_EXP || (FAULT_REPEAT_COUNT == FAULT_REPEAT_LIMIT) ||
                    (WATCHDOG_FAIL_COUNT == WATCHDOG_FAIL_LIMIT) || THERMAL_SHUTDOWN;
  assign stop_ev = fault_ev || pin_dn || sd_exp;

  ////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (up_ev)
          next_state = ST_UP;
      end
      ST_UP, ST_SBUP: begin
        if (stop_ev)
          next_state = ST_DN;
        else if (seq_done)
          next_state = ST_RUN;
      end
      ST_RUN: begin
        if (stop_ev)
          next_state = ST_DN;
        else if (STANDBY_REQ)
          next_state = ST_SBDN;
      end
      ST_SBDN: begin
        if (stop_ev)
          next_state = ST_DN;
        else if (seq_done)
          next_state = ST_STBY;
      end
      ST_STBY: begin
        if (stop_ev)
          next_state = ST_DN;
        else if (!STANDBY_REQ)
          next_state = ST_SBUP;
      end
      ST_DN: begin
        // R15 hard fault detours through fail-safe
        if (seq_done)
          next_state = hard ? ST_FS : ST_OFF;
      end
      ST_FS: next_state = ST_OFF;
      default: next_state = ST_OFF;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= ST_OFF;
      hard <= 1'b0;
    end else begin
      state <= next_state;
      if (state == ST_OFF)
        hard <= 1'b0;
      else if (on_st && next_state == ST_DN)
        hard <= fault_ev;
    end
  end

  ////////////////////////////////////////////////////////////////
  // R1 period per time base code
  always_comb begin
    case (live_tb)
      2'h0: tb_period = 32'(TB0_CYC);
      2'h1: tb_period = 32'(TB1_CYC);
      2'h2: tb_period = 32'(TB2_CYC);
      default: tb_period = 32'(TB3_CYC);
    endcase
  end

  // R24 tick counter, restarted on each state change
  always_ff @(posedge CLK) begin
    if (RST || next_state != state || !(is_up || is_dn) || tick)
      tb_cnt <= 32'h0;
    else
      tb_cnt <= tb_cnt + 32'h1;
  end
  assign tick = (is_up || is_dn) && tb_cnt == tb_period - 32'h1;

  // R24 slot counter
  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt <= 9'h000;
    end else if (next_state != state) begin
      if (next_state == ST_UP || next_state == ST_SBUP)
        cnt <= 9'h001;
      else
        cnt <= top_field(next_scope, slot);
    end else if (tick && is_up && cnt != 9'h1ff) begin
      cnt <= cnt + 9'h001;
    end else if (tick && is_dn && cnt != 9'h000) begin
      // R16 grouped mode drops every remaining output together
      cnt <= grouped ? 9'h000 : cnt - 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////
  // per-output enable
  for (genvar i = 0; i < N; i++) begin : g_out
    always_ff @(posedge CLK) begin
      if (RST) begin
        out_en[i] <= 1'b0;
      end else begin
        case (state)
          ST_UP, ST_SBUP: begin
            // R4 field n means slot n-1, on once the counter passes it
            // R5 slot 0 enables in the first cycle
            if (scope[i] && slot[i] != 8'h00 && 9'(slot[i]) <= cnt)
              out_en[i] <= 1'b1;
            // R6 unslotted host reset rises in the same cycle as the last output
            // R7 slave mode releases it on run entry
            else if (i == HR && state == ST_UP && slot[i] == 8'h00 && seq_done)
              out_en[i] <= 1'b1;
          end
          ST_DN, ST_SBDN: begin
            // R19 zero fields drop now, the rest from the top down
            // R20 power-good output uses its own field here
            if (scope[i] && (slot[i] == 8'h00 || 9'(slot[i]) > cnt))
              out_en[i] <= 1'b0;
          end
          ST_OFF, ST_FS: out_en[i] <= 1'b0;
          default: out_en[i] <= out_en[i];
        endcase
      end
    end
  end

  assign REG_ENABLE = out_en[NREG-1:0];
  assign POWER_GOOD_PIN = out_en[NREG];
  assign HOST_RESET_N = out_en[HR];
  assign FAIL_SAFE = (state == ST_FS);

  ////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      live_tb <= `PSS_TB_RST;
      edge_mode <= 1'b0;
      slot <= {N{`PSS_SLOT_RST}};
    end else if (state == ST_OFF) begin
      // R21 off pass reloads from nonvolatile values
      live_tb <= DEF_TIME_BASE_SEL;
      edge_mode <= DEF_EDGE_MODE;
      slot <= DEF_SLOT_FIELD;
    end else if (WR) begin
      // R2 time base writable while on
      if (ADDR == `PSS_A_CTRL)
        live_tb <= WDATA[`PSS_CTRL_TB_LO +: 2];
      for (int i = 0; i < N; i++) begin
        // R3 slot field per output
        if (ADDR == `PSS_A_SLOT0 + 8'(4 * i))
          slot[i] <= WDATA;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      grouped <= 1'b0;
      irq_mask <= `PSS_MASK_RST;
      stby_keep <= NREG'(`PSS_KEEP_RST);
    end else if (WR) begin
      if (ADDR == `PSS_A_CTRL)
        grouped <= WDATA[`PSS_CTRL_GRP];
      if (ADDR == `PSS_A_MASK)
        irq_mask <= WDATA[2:0];
      if (ADDR == `PSS_A_KEEP)
        stby_keep <= WDATA[NREG-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // software shutdown
  assign sd_set = WR && ADDR == `PSS_A_CTRL && WDATA[`PSS_CTRL_SDREQ] && !sd_req && on_st;
  assign sd_clr = WR && ADDR == `PSS_A_FLAGS && WDATA[`PSS_F_SD];
  assign sd_exp = sd_req && flags[`PSS_F_SD] && sd_cnt == 32'(SDWN_CYC) - 32'h1;

  always_ff @(posedge CLK) begin
    if (RST) begin
      sd_req <= 1'b0;
      sd_cnt <= 32'h0;
    end else begin
      // R12 request starts the timer
      if (sd_set)
        sd_req <= 1'b1;
      // R13 request self-clears once its flag is cleared
      else if (state == ST_OFF || (sd_clr && !sd_exp))
        sd_req <= 1'b0;
      // R13 cancel resets the timer
      if (sd_req && flags[`PSS_F_SD] && !sd_clr && !sd_exp)
        sd_cnt <= sd_cnt + 32'h1;
      else
        sd_cnt <= 32'h0;
    end
  end

  // sticky flags, a set beats a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      flags <= 3'h0;
      INTERRUPT_OUT_N <= 1'b1;
    end else begin
      // R9 every standby to run end
      if (state == ST_SBUP && next_state == ST_RUN)
        flags[`PSS_F_UP] <= 1'b1;
      else if (WR && ADDR == `PSS_A_FLAGS && WDATA[`PSS_F_UP])
        flags[`PSS_F_UP] <= 1'b0;
      // R18 every run to standby end
      if (state == ST_SBDN && next_state == ST_STBY)
        flags[`PSS_F_DN] <= 1'b1;
      else if (WR && ADDR == `PSS_A_FLAGS && WDATA[`PSS_F_DN])
        flags[`PSS_F_DN] <= 1'b0;
      // R12 shutdown flag
      if (sd_set)
        flags[`PSS_F_SD] <= 1'b1;
      else if (sd_clr)
        flags[`PSS_F_SD] <= 1'b0;
      INTERRUPT_OUT_N <= ~|(flags & ~irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////
  // read port, unmapped reads return zero
  always_ff @(posedge CLK) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= 8'h00;
      if (RD) begin
        case (ADDR)
          `PSS_A_CTRL: RDATA <= {3'h0, edge_mode, sd_req, grouped, live_tb};
          `PSS_A_FLAGS: RDATA <= {5'h00, flags};
          `PSS_A_MASK: RDATA <= {5'h00, irq_mask};
          `PSS_A_STATE: RDATA <= {4'h0, hard, state};
          `PSS_A_OUTEN: RDATA <= 8'(out_en);
          `PSS_A_KEEP: RDATA <= 8'(stby_keep);
          default: begin
            for (int i = 0; i < N; i++) begin
              if (ADDR == `PSS_A_SLOT0 + 8'(4 * i))
                RDATA <= slot[i];
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_slot_zero_off: assert property ( // R3
    (state == ST_UP && slot[0] == 8'h00 && !out_en[0]) |=> !out_en[0])
    else $error("zero-slot output enabled");
  a_slot0_now: assert property ( // R5
    (state == ST_OFF && next_state == ST_UP && DEF_SLOT_FIELD[7:0] == 8'h01) |-> ##2 out_en[0])
    else $error("slot 0 output late");
  a_host_rst_last: assert property ( // R6
    (state == ST_UP && seq_done && slot[HR] == 8'h00 && !stop_ev) |=> out_en[HR] && state == ST_RUN)
    else $error("host reset not released");
  a_pwrup_gate: assert property ( // R22
    (state == ST_OFF && next_state == ST_UP) |-> pwr_ok)
    else $error("power up taken with error present");
  a_level_down: assert property ( // R10
    (state == ST_RUN && !edge_mode && !pon_s) |=> state == ST_DN)
    else $error("pin low did not power down");
  a_sd_irq: assert property ( // R12
    (sd_set && !irq_mask[`PSS_F_SD]) |=> sd_req ##1 !INTERRUPT_OUT_N)
    else $error("shutdown request not flagged");
  a_sd_cancel: assert property ( // R13
    (sd_clr && sd_req && !sd_exp) |=> !sd_req && sd_cnt == 32'h0)
    else $error("shutdown not cancelled");
  a_fault_down: assert property ( // R14
    (state == ST_RUN && fault_ev) |=> state == ST_DN && hard)
    else $error("fault did not power down");
  a_fail_safe: assert property ( // R15
    (state == ST_DN && hard && seq_done) |=> state == ST_FS ##1 state == ST_OFF)
    else $error("fail-safe skipped");
  a_grouped_drop: assert property ( // R16
    (state == ST_DN && grouped && tick && next_state == ST_DN) |=> cnt == 9'h000)
    else $error("grouped down not at once");
  a_reload_off: assert property ( // R21
    (state == ST_OFF) |=> live_tb == $past(DEF_TIME_BASE_SEL))
    else $error("time base not reloaded");
  a_dn_flag: assert property ( // R18
    (state == ST_SBDN && next_state == ST_STBY) |=> flags[`PSS_F_DN])
    else $error("power-down flag missing");

  c_seq_up: cover property (state == ST_UP ##1 state == ST_RUN);
  c_stby_round: cover property (state == ST_SBUP ##1 state == ST_RUN);
  c_sd_cancel: cover property (sd_clr && sd_req);
  c_fail_safe: cover property (state == ST_FS);
endmodule

`default_nettype wire

// ==== dv/pss_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"
module pss_host_model (
  // clock
  input wire logic CLK,
  // register port
  output logic [7:0] ADDR,
  output logic [7:0] WDATA,
  output logic WR,
  output logic RD,
  input wire logic [7:0] RDATA,
  // power-on pin
  output logic POWER_ON_PIN
);
  initial begin
    ADDR = 8'h00;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
    POWER_ON_PIN = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // idle bus shows the inverse of the last value, so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    ADDR <= ~a;
    WDATA <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    ADDR <= ~a;
    @(posedge CLK);
    d = RDATA;
  endtask
  task automatic cancel_sd();
    wr(`PSS_A_FLAGS, 8'h04);
  endtask
  task automatic pin(input logic v);
    @(posedge CLK);
    POWER_ON_PIN <= v;
  endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"
module tb import pss_pkg::*;;
  // short periods keep the run small
  localparam int per[4] = '{8, 12, 16, 20};
  localparam int sdwn = 40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, pin;
  logic sby;
  logic ftim;
  logic dedge;
  logic [1:0] dtb;
  logic [47:0] dslot;
  logic [3:0] fcnt, wcnt, blk;
  logic [3:0] flim, wlim;
  logic [3:0] ren;
  logic pg, hrn, irqn, fs;
  logic [6:0] outs;
  logic [6:0] prev = 7'h00;
  int cyc = 0;
  int n_fail = 0;
  int num_checks = 0;
  int t_rise[7];
  int t_fall[7];
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  pss_top #(.TB0_CYC(per[0]), .TB1_CYC(per[1]), .TB2_CYC(per[2]), .TB3_CYC(per[3]),
    .SDWN_CYC(sdwn), .HOLD_CYC(5), .DBNC_CYC(5)) uut (
    .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .DEF_TIME_BASE_SEL(dtb), .DEF_SLOT_FIELD(dslot), .DEF_EDGE_MODE(dedge),
    .POWER_ON_PIN(pin), .STANDBY_REQ(sby), .FAULT_TIMER_EXP(ftim),
    .FAULT_REPEAT_COUNT(fcnt), .FAULT_REPEAT_LIMIT(flim),
    .WATCHDOG_FAIL_COUNT(wcnt), .WATCHDOG_FAIL_LIMIT(wlim), .THERMAL_SHUTDOWN(blk[3]),
    .TRIM_ERROR_FLAG(blk[0]), .CONFIG_LOAD_ERROR_FLAG(blk[1]),
    .SELF_TEST_ERROR_FLAG(blk[2]), .REG_ENABLE(ren), .POWER_GOOD_PIN(pg),
    .HOST_RESET_N(hrn), .INTERRUPT_OUT_N(irqn), .FAIL_SAFE(fs));
  pss_host_model host (.CLK(clk), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .POWER_ON_PIN(pin));
  ////////////////////////////////////////////////////////////////
  // edge times of every output except the interrupt, for slot spacing checks
  assign outs = {fs, hrn, pg, ren};
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prev <= outs;
    for (int i = 0; i < 7; i++) begin
      if (outs[i] === 1'b1 && prev[i] === 1'b0) t_rise[i] <= cyc;
      if (outs[i] === 1'b0 && prev[i] === 1'b1) t_fall[i] <= cyc;
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_out(input logic [6:0] m, input logic [6:0] v, input int lim);
    int i;
    i = 0;
    while ((outs & m) !== v) begin
      @(posedge clk);
      i++;
      if (i > lim) begin
        chk({9'h0, outs & m}, {9'h0, v});
        finish_test();
      end
    end
    // edge recorder updates on this edge, let it land first
    #1;
  endtask
  task automatic wait_flag(input logic [7:0] f);
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < 100 && (d & f) !== f; i++) host.rd(`PSS_A_FLAGS, d);
    chk(d & f, f);
    if ((d & f) !== f) finish_test();
  endtask
  task automatic up();
    host.pin(1'b1);
    wait_out(7'h20, 7'h20, 400);
  endtask
  // pin sync delay first, then allow the down pass to reach off
  task automatic down();
    host.pin(1'b0);
    repeat (4) @(posedge clk);
    wait_out(7'h3f, 7'h00, 400);
    repeat (100) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] d;
    chk(hrn, 1'b0);
    chk(irqn, 1'b1);
    host.rd(`PSS_A_MASK, d);
    chk(d, `PSS_MASK_RST);
    host.rd(`PSS_A_KEEP, d);
    chk(d, `PSS_KEEP_RST);
    host.rd(8'hfc, d);
    chk(d, 8'h00);
    host.rd(`PSS_A_SLOT0, d);
    chk(d, dslot[7:0]);
    $display("reset test done");
  endtask
  task automatic t_seq();
    for (int s = 0; s < 4; s++) begin
      dtb <= s[1:0];
      up();
      chk(t_rise[3] - t_rise[0], per[s]);
      chk(t_rise[1] - t_rise[0], 2 * per[s]);
      chk(t_rise[4] - t_rise[0], 3 * per[s]);
      chk(ren, 4'hb);
      chk(t_rise[5] >= t_rise[4] && t_rise[5] <= t_rise[4] + per[s] + 2, 1'b1);
      host.wr(`PSS_A_CTRL, 8'(3 - s));
      down();
      chk(t_fall[1] - t_fall[4], per[3 - s]);
      chk(t_fall[3] - t_fall[4], 2 * per[3 - s]);
      chk(t_fall[0] - t_fall[4], 3 * per[3 - s]);
      chk(t_fall[5] <= t_fall[4], 1'b1);
    end
    $display("sequence test done");
  endtask
  task automatic t_group();
    up();
    host.wr(`PSS_A_CTRL, 8'h04);
    down();
    chk(t_fall[1], t_fall[0]);
    chk(t_fall[3], t_fall[0]);
    chk(t_fall[4], t_fall[0]);
    $display("group test done");
  endtask
  task automatic t_sby();
    logic [7:0] d;
    logic [7:0] kp[2];
    kp = '{8'h0f, 8'h09};
    up();
    host.wr(`PSS_A_FLAGS, 8'h07);
    foreach (kp[k]) begin
      host.wr(`PSS_A_KEEP, kp[k]);
      sby <= 1'b1;
      wait_flag(8'h02);
      chk(ren, 4'hb & kp[k][3:0]);
      chk(irqn, 1'b0);
      host.wr(`PSS_A_FLAGS, 8'h02);
      sby <= 1'b0;
      wait_flag(8'h01);
      chk(ren, 4'hb);
      host.wr(`PSS_A_FLAGS, 8'h01);
      host.rd(`PSS_A_STATE, d);
      chk(d[2:0], ST_RUN);
      chk(irqn, 1'b1);
    end
    $display("standby test done");
  endtask
  task automatic t_sd();
    logic [7:0] d;
    int n;
    host.wr(`PSS_A_CTRL, 8'h08);
    repeat (3) @(posedge clk);
    chk(irqn, 1'b0);
    host.rd(`PSS_A_FLAGS, d);
    chk(d, 8'h04);
    host.cancel_sd();
    host.rd(`PSS_A_CTRL, d);
    chk(d, 8'h00);
    repeat (sdwn + 20) @(posedge clk);
    chk(ren, 4'hb);
    host.wr(`PSS_A_MASK, 8'h04);
    host.wr(`PSS_A_CTRL, 8'h08);
    n = cyc;
    repeat (3) @(posedge clk);
    chk(irqn, 1'b1);
    wait_out(7'h0f, 7'h00, 300);
    chk(cyc - n >= sdwn, 1'b1);
    down();
    host.wr(`PSS_A_MASK, 8'h00);
    $display("shutdown test done");
  endtask
  task automatic t_fault();
    for (int c = 0; c < 4; c++) begin
      blk <= 4'h1 << c;
      host.pin(1'b1);
      repeat (30) @(posedge clk);
      chk(ren, 4'h0);
      blk <= 4'h0;
      up();
      @(posedge clk);
      case (c)
        0: blk[3] <= 1'b1;
        1: ftim <= 1'b1;
        2: begin
          flim <= 4'ha;
          fcnt <= 4'ha;
        end
        default: begin
          wlim <= 4'h7;
          wcnt <= 4'h7;
        end
      endcase
      wait_out(7'h40, 7'h40, 300);
      chk(ren, 4'h0);
      @(posedge clk);
      blk <= 4'h0;
      ftim <= 1'b0;
      fcnt <= 4'h0;
      wcnt <= 4'h0;
      down();
    end
    $display("fault test done");
  endtask
  task automatic t_misc();
    dslot <= 48'h0;
    up();
    chk(ren, 4'h0);
    chk(pg, 1'b0);
    down();
    dslot <= 48'h00_04_02_00_03_01;
    dedge <= 1'b1;
    host.pin(1'b1);
    repeat (10) @(posedge clk);
    host.pin(1'b0);
    wait_out(7'h20, 7'h20, 400);
    chk(ren, 4'hb);
    host.pin(1'b1);
    repeat (10) @(posedge clk);
    host.pin(1'b0);
    repeat (4) @(posedge clk);
    chk(ren, 4'hb);
    wait_out(7'h0f, 7'h00, 400);
    @(posedge clk);
    dedge <= 1'b0;
    $display("pin mode test done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    sby <= 1'b0;
    ftim <= 1'b0;
    dedge <= 1'b0;
    dtb <= 2'h0;
    dslot <= 48'h00_04_02_00_03_01;
    fcnt <= 4'h0;
    wcnt <= 4'h0;
    blk <= 4'h0;
    flim <= 4'h5;
    wlim <= 4'h3;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_seq();
    t_group();
    t_sby();
    t_sd();
    t_fault();
    t_misc();
    finish_test();
  end
endmodule
`default_nettype wire
